// >>> core/iqgpc_defines.svh
`ifndef IQGPC_DEFINES_SVH
`define IQGPC_DEFINES_SVH

// Register offsets on the plain register port
`define IQGPC_ADDR_CFG1       8'h01
`define IQGPC_ADDR_GAIN_A     8'h0c
`define IQGPC_ADDR_GAIN_B     8'h0d
`define IQGPC_ADDR_DLY_GAIN_D 8'h0f
`define IQGPC_ADDR_PHASE_DUAL 8'h10
`define IQGPC_ADDR_SYNC_EN    8'h1e

// Field positions
`define IQGPC_LAG_AB_MSB      15
`define IQGPC_LAG_AB_LSB      14
`define IQGPC_LAG_CD_MSB      13
`define IQGPC_LAG_CD_LSB      12
`define IQGPC_GAIN_MSB        10
`define IQGPC_DUAL_MSB        13
`define IQGPC_DUAL_LSB        12
`define IQGPC_PHASE_MSB       11
`define IQGPC_CFG1_DUAL_OFF   8
`define IQGPC_SYNC_EN_BIT     0

// Reset values and codes
`define IQGPC_GAIN_UNITY      11'h400
`define IQGPC_PHASE_RESET     12'h000
`define IQGPC_LAG_RESET       2'h0
`define IQGPC_DUAL_CODE       2'h3
`define IQGPC_SYNC_EN_RESET   1'h1
`define IQGPC_CFG1_RESET      16'h0100

`endif

// >>> core/iqgpc_pkg.sv
package iqgpc_pkg;

  typedef logic signed [15:0] iqgpc_sample_t;

  // One converter sample per channel
  typedef struct packed {
    iqgpc_sample_t a;
    iqgpc_sample_t b;
    iqgpc_sample_t c;
    iqgpc_sample_t d;
  } iqgpc_quad_s;

  // Correction settings seen by the arithmetic
  typedef struct packed {
    logic [10:0] gain_a;
    logic [10:0] gain_b;
    logic [11:0] phase_ab;
  } iqgpc_corr_s;

endpackage : iqgpc_pkg

// >>> core/iqgpc_core.sv
// What this block does
// - Delay AB outputs 0..3 cycles, reset zero
// - Delay CD outputs 0..3 cycles, reset zero
// - Fourth gain is 11-bit unsigned word
// - Gain binary point between bits 9, 10
// - AB phase 12-bit signed, scaled -0.5..0.49975
// - Add B times phase into A
// - Phase write auto-syncs staged A, B, phase
// - A, B gain writes alone leave active settings; a D gain write applies at once
// - Dual mode needs cfg bit clear, field 11
// - Dual mode keeps only channels B, C
// - Reserved bits reset and read zero
// - A and B gains share D format
`timescale 1ns/10ps
`include "iqgpc_defines.svh"

module iqgpc_core (
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [15:0]           reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic [15:0]                reg_rdata_out,
  input  wire iqgpc_pkg::iqgpc_quad_s samples_in,
  output iqgpc_pkg::iqgpc_quad_s     samples_out,
  output logic                       dual_mode_out
);

  // Gain product: binary point between bits 9 and 10 of the gain
  function automatic logic signed [17:0] gain_term(input logic signed [15:0] s,
                                                   input logic [10:0] g);
    logic signed [27:0] p;
    p = s * $signed({1'b0, g});
    return p[27:10];
  endfunction : gain_term

  // Phase product: 12-bit two's complement scaled by 2^-12
  function automatic logic signed [17:0] phase_term(input logic signed [15:0] s,
                                                    input logic [11:0] ph);
    logic signed [27:0] p;
    p = s * $signed(ph);
    return {{2{p[27]}}, p[27:12]};
  endfunction : phase_term

  // Clip to the 16-bit sample range so overflow does not wrap
  function automatic logic signed [15:0] sat16(input logic signed [17:0] x);
    logic signed [15:0] r;
    r = x[15:0];
    if (x > 18'sh07fff) begin
      r = 16'sh7fff;
    end else if (x < -18'sh08000) begin
      r = 16'sh8000;
    end
    return r;
  endfunction : sat16

  // Reset release through two flops
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Software-visible staging and control state
  logic [10:0] stage_gain_a_reg, stage_gain_a_next;
  logic [10:0] stage_gain_b_reg, stage_gain_b_next;
  logic [10:0] gain_d_reg, gain_d_next;
  logic [1:0]  lag_ab_reg, lag_ab_next;
  logic [1:0]  lag_cd_reg, lag_cd_next;
  logic [11:0] phase_stage_reg, phase_stage_next;
  logic [1:0]  dual_ena_reg, dual_ena_next;
  logic [15:0] cfg1_reg, cfg1_next;
  logic        sync_en_reg, sync_en_next;
  logic        wr_gain_a, wr_gain_b, wr_phase, auto_sync;

  assign wr_gain_a = reg_wr_in && (reg_addr_in == `IQGPC_ADDR_GAIN_A);
  assign wr_gain_b = reg_wr_in && (reg_addr_in == `IQGPC_ADDR_GAIN_B);
  assign wr_phase  = reg_wr_in && (reg_addr_in == `IQGPC_ADDR_PHASE_DUAL);
  assign auto_sync = wr_phase && sync_en_reg;

  // Register writes; reserved bits are never stored
  always_comb begin
    stage_gain_a_next = stage_gain_a_reg;
    stage_gain_b_next = stage_gain_b_reg;
    gain_d_next       = gain_d_reg;
    lag_ab_next       = lag_ab_reg;
    lag_cd_next       = lag_cd_reg;
    phase_stage_next  = phase_stage_reg;
    dual_ena_next     = dual_ena_reg;
    cfg1_next         = cfg1_reg;
    sync_en_next      = sync_en_reg;
    if (wr_gain_a) begin
      stage_gain_a_next = reg_wdata_in[`IQGPC_GAIN_MSB:0];
    end
    if (wr_gain_b) begin
      stage_gain_b_next = reg_wdata_in[`IQGPC_GAIN_MSB:0];
    end
    if (reg_wr_in && (reg_addr_in == `IQGPC_ADDR_DLY_GAIN_D)) begin
      lag_ab_next = reg_wdata_in[`IQGPC_LAG_AB_MSB:`IQGPC_LAG_AB_LSB];
      lag_cd_next = reg_wdata_in[`IQGPC_LAG_CD_MSB:`IQGPC_LAG_CD_LSB];
      gain_d_next = reg_wdata_in[`IQGPC_GAIN_MSB:0];
    end
    if (wr_phase) begin
      dual_ena_next    = reg_wdata_in[`IQGPC_DUAL_MSB:`IQGPC_DUAL_LSB];
      phase_stage_next = reg_wdata_in[`IQGPC_PHASE_MSB:0];
    end
    if (reg_wr_in && (reg_addr_in == `IQGPC_ADDR_CFG1)) begin
      cfg1_next = reg_wdata_in;
    end
    if (reg_wr_in && (reg_addr_in == `IQGPC_ADDR_SYNC_EN)) begin
      sync_en_next = reg_wdata_in[`IQGPC_SYNC_EN_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stage_gain_a_reg <= `IQGPC_GAIN_UNITY;
      stage_gain_b_reg <= `IQGPC_GAIN_UNITY;
      gain_d_reg       <= `IQGPC_GAIN_UNITY;
      lag_ab_reg       <= `IQGPC_LAG_RESET;
      lag_cd_reg       <= `IQGPC_LAG_RESET;
      phase_stage_reg  <= `IQGPC_PHASE_RESET;
      dual_ena_reg     <= 2'h0;
      cfg1_reg         <= `IQGPC_CFG1_RESET;
      sync_en_reg      <= `IQGPC_SYNC_EN_RESET;
    end else begin
      stage_gain_a_reg <= stage_gain_a_next;
      stage_gain_b_reg <= stage_gain_b_next;
      gain_d_reg       <= gain_d_next;
      lag_ab_reg       <= lag_ab_next;
      lag_cd_reg       <= lag_cd_next;
      phase_stage_reg  <= phase_stage_next;
      dual_ena_reg     <= dual_ena_next;
      cfg1_reg         <= cfg1_next;
      sync_en_reg      <= sync_en_next;
    end
  end

  // Active settings: loaded together only by the auto-sync
  iqgpc_pkg::iqgpc_corr_s act_reg, act_next;
  logic                   dual_reg, dual_next;
  always_comb begin
    act_next = act_reg;
    if (auto_sync) begin
      act_next.gain_a   = stage_gain_a_reg;
      act_next.gain_b   = stage_gain_b_reg;
      act_next.phase_ab = reg_wdata_in[`IQGPC_PHASE_MSB:0];
    end
    dual_next = !cfg1_reg[`IQGPC_CFG1_DUAL_OFF] && (dual_ena_reg == `IQGPC_DUAL_CODE);
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      act_reg  <= '{gain_a: `IQGPC_GAIN_UNITY, gain_b: `IQGPC_GAIN_UNITY,
                    phase_ab: `IQGPC_PHASE_RESET};
      dual_reg <= 1'b0;
    end else begin
      act_reg  <= act_next;
      dual_reg <= dual_next;
    end
  end

  // Correction arithmetic, then a fixed tap line the lag fields choose from
  iqgpc_pkg::iqgpc_quad_s corr_reg, corr_next;
  iqgpc_pkg::iqgpc_quad_s dly_reg [3], dly_next [3];
  iqgpc_pkg::iqgpc_quad_s out_reg, out_next;
  always_comb begin
    corr_next.a = sat16(gain_term(samples_in.a, act_reg.gain_a)
                        + phase_term(samples_in.b, act_reg.phase_ab));
    corr_next.b = sat16(gain_term(samples_in.b, act_reg.gain_b));
    corr_next.c = samples_in.c;
    corr_next.d = sat16(gain_term(samples_in.d, gain_d_reg));
    if (dual_reg) begin
      corr_next.a = 16'sh0000;
      corr_next.d = 16'sh0000;
    end
    dly_next[0] = corr_reg;
    dly_next[1] = dly_reg[0];
    dly_next[2] = dly_reg[1];
    // Whole pairs move together so A and B never skew
    out_next.a = (lag_ab_reg == 2'h0) ? corr_reg.a : dly_reg[lag_ab_reg - 2'h1].a;
    out_next.b = (lag_ab_reg == 2'h0) ? corr_reg.b : dly_reg[lag_ab_reg - 2'h1].b;
    out_next.c = (lag_cd_reg == 2'h0) ? corr_reg.c : dly_reg[lag_cd_reg - 2'h1].c;
    out_next.d = (lag_cd_reg == 2'h0) ? corr_reg.d : dly_reg[lag_cd_reg - 2'h1].d;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      corr_reg <= '0;
      dly_reg  <= '{default: '0};
      out_reg  <= '0;
    end else begin
      corr_reg <= corr_next;
      dly_reg  <= dly_next;
      out_reg  <= out_next;
    end
  end

  // Read port; unmapped offsets answer zero
  logic [15:0] rdata_reg, rdata_next;
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `IQGPC_ADDR_GAIN_A:     rdata_next = {5'h00, stage_gain_a_reg};
        `IQGPC_ADDR_GAIN_B:     rdata_next = {5'h00, stage_gain_b_reg};
        `IQGPC_ADDR_DLY_GAIN_D: rdata_next = {lag_ab_reg, lag_cd_reg, 1'b0, gain_d_reg};
        `IQGPC_ADDR_PHASE_DUAL: rdata_next = {2'h0, dual_ena_reg, phase_stage_reg};
        `IQGPC_ADDR_CFG1:       rdata_next = cfg1_reg;
        `IQGPC_ADDR_SYNC_EN:    rdata_next = {15'h0000, sync_en_reg};
        default:                rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign samples_out   = out_reg;
  assign dual_mode_out = dual_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  // Phase write with sync on, then the load of all three settings
  sequence sync_write_s;
    wr_phase && sync_en_reg;
  endsequence
  sequence loaded_s;
    act_reg.phase_ab == $past(reg_wdata_in[11:0])
      && act_reg.gain_a == $past(stage_gain_a_reg)
      && act_reg.gain_b == $past(stage_gain_b_reg);
  endsequence

  ab_lag_three_a: assert property ($past(lag_ab_reg) == 2'h3
    |-> samples_out.a == $past(corr_reg.a, 4) && samples_out.b == $past(corr_reg.b, 4))
    else $error("AB pair lag of three not applied");
  cd_lag_zero_a: assert property ($past(lag_cd_reg) == 2'h0
    |-> samples_out.c == $past(corr_reg.c) && samples_out.d == $past(corr_reg.d))
    else $error("CD pair lag of zero not applied");
  d_unity_gain_a: assert property ($past(gain_d_reg) == 11'h400 && !$past(dual_reg)
    |-> corr_reg.d == $past(samples_in.d))
    else $error("Unity fourth gain altered sample");
  d_half_gain_a: assert property ($past(gain_d_reg) == 11'h200 && !$past(dual_reg)
    |-> corr_reg.d == ($past(samples_in.d) >>> 1))
    else $error("Gain binary point misplaced");
  a_no_phase_a: assert property ($past(act_reg) == {11'h400, 11'h400, 12'h000}
    && !$past(dual_reg) |-> corr_reg.a == $past(samples_in.a))
    else $error("Zero phase changed A sample");
  a_phase_sum_a: assert property ($past(act_reg.gain_a) == 11'h000
    && $past(act_reg.phase_ab) == 12'h400 && !$past(dual_reg)
    |-> corr_reg.a == ($past(samples_in.b) >>> 2))
    else $error("B times phase not added into A");
  auto_sync_a: assert property (sync_write_s |=> loaded_s)
    else $error("Auto-sync did not load settings");
  gain_hold_a: assert property ((wr_gain_a || wr_gain_b) && !wr_phase
    |=> $stable(act_reg))
    else $error("Gain write changed active settings");
  dual_entry_a: assert property (dual_reg
    == (!$past(cfg1_reg[8]) && $past(dual_ena_reg) == 2'h3))
    else $error("Dual mode entry condition wrong");
  dual_chan_a: assert property ($past(dual_reg) |-> corr_reg.a == 16'sh0000
    && corr_reg.d == 16'sh0000 && corr_reg.c == $past(samples_in.c))
    else $error("Dual mode left A or D active");
  reserved_zero_a: assert property (reg_rd_in && reg_addr_in == 8'h10
    |=> reg_rdata_out[15:14] == 2'h0)
    else $error("Reserved phase bits read nonzero");
  b_unity_gain_a: assert property ($past(act_reg.gain_b) == 11'h400 && !$past(dual_reg)
    ##0 1'b1 |-> corr_reg.b == $past(samples_in.b))
    else $error("Unity B gain altered sample");
  pair_aligned_a: assert property ($past(lag_ab_reg) == $past(lag_cd_reg)
    && $past(lag_ab_reg) == 2'h1 |-> samples_out.a == $past(corr_reg.a, 2)
    && samples_out.c == $past(corr_reg.c, 2))
    else $error("Pairs not shifted alike");

  // Opposite lag ends for each pair, so both ends of each tap mux are watched
  ab_lag_zero_a: assert property ($past(lag_ab_reg) == 2'h0
    |-> samples_out.a == $past(corr_reg.a) && samples_out.b == $past(corr_reg.b))
    else $error("AB pair lag of zero not applied");
  cd_lag_three_a: assert property ($past(lag_cd_reg) == 2'h3
    |-> samples_out.c == $past(corr_reg.c, 4) && samples_out.d == $past(corr_reg.d, 4))
    else $error("CD pair lag of three not applied");

  // With sync off a phase write only stages; the active set must not move
  sync_off_hold_a: assert property (wr_phase && !sync_en_reg
    |=> $stable(act_reg))
    else $error("Phase write without sync changed settings");

  // Channel C carries no correction here, in either mode
  c_pass_a: assert property (corr_reg.c == $past(samples_in.c))
    else $error("Channel C sample altered");

endmodule : iqgpc_core

// >>> sim/iqgpc_upstream_model.sv
`timescale 1ns/10ps
// Upstream sample source: one new quad sample on every rising converter edge
module iqgpc_upstream_model (
  input  wire logic                   clk_in,
  input  wire iqgpc_pkg::iqgpc_quad_s next_in,
  output iqgpc_pkg::iqgpc_quad_s      samples_out
);
  // Registered like real logic, so changes land just after the edge
  always_ff @(posedge clk_in) begin
    samples_out <= next_in;
  end
endmodule : iqgpc_upstream_model

// >>> sim/tb.sv
`timescale 1ns/10ps
`include "iqgpc_defines.svh"
module tb;
  logic                   clk_in       = 1'b0;
  logic                   arst_n_in    = 1'b1;
  logic [7:0]             reg_addr_in  = 8'h00;
  logic [15:0]            reg_wdata_in = 16'h0000;
  logic                   reg_wr_in    = 1'b0;
  logic                   reg_rd_in    = 1'b0;
  logic [15:0]            reg_rdata_out;
  iqgpc_pkg::iqgpc_quad_s drive_q      = '0;
  iqgpc_pkg::iqgpc_quad_s samples_in;
  iqgpc_pkg::iqgpc_quad_s samples_out;
  iqgpc_pkg::iqgpc_quad_s s;
  logic                   dual_mode_out;
  logic [15:0]            rd_val;
  logic [10:0]            ga           = 11'h400;
  logic [10:0]            gb           = 11'h400;
  logic [10:0]            gd           = 11'h400;
  logic [11:0]            ph           = 12'h000;
  logic                   dual         = 1'b0;
  logic [7:0]             ra [5]       = '{8'h0f, 8'h10, 8'h0c, 8'h0d, 8'h33};
  logic [15:0]            re [5]       = '{16'h0400, 16'h0000, 16'h0400, 16'h0400, 16'h0000};
  int                     failures     = 0;
  int                     total_checks = 0;

  // 25 MHz converter clock
  always #20 clk_in = ~clk_in;

  iqgpc_upstream_model i_iqgpc_upstream_model (
    .clk_in(clk_in), .next_in(drive_q), .samples_out(samples_in));

  iqgpc_core i_iqgpc_core (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .samples_in(samples_in),
    .samples_out(samples_out), .dual_mode_out(dual_mode_out));

  // Clip to the 16-bit signed sample range
  function automatic logic [15:0] sat(input logic signed [39:0] v);
    if (v > 40'sh7fff) return 16'h7fff;
    if (v < -40'sh8000) return 16'h8000;
    return v[15:0];
  endfunction : sat

  // Expected corrected quad from the settings the bench believes active
  function automatic iqgpc_pkg::iqgpc_quad_s model(input iqgpc_pkg::iqgpc_quad_s q);
    logic signed [39:0] a, b, d, g, p;
    a = q.a;
    b = q.b;
    d = q.d;
    p = $signed(ph);
    g = {29'h0, ga};
    model.a = dual ? 16'h0000 : sat(((a * g) >>> 10) + ((b * p) >>> 12));
    g = {29'h0, gb};
    model.b = sat((b * g) >>> 10);
    model.c = q.c;
    g = {29'h0, gd};
    model.d = dual ? 16'h0000 : sat((d * g) >>> 10);
  endfunction : model

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chkq(input iqgpc_pkg::iqgpc_quad_s got, input iqgpc_pkg::iqgpc_quad_s exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected quad at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkq

  // One-cycle write strobe, released on the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 rd_val = reg_rdata_out;
  endtask : rd

  // Hold the stream long enough to cover any lag
  task automatic steady(input iqgpc_pkg::iqgpc_quad_s q);
    @(posedge clk_in);
    drive_q <= q;
    repeat (8) @(posedge clk_in);
    #1;
  endtask : steady

  // Step the stream and watch the edge where each pair turns over
  task automatic lag_step(input logic [1:0] la, input logic [1:0] lc);
    iqgpc_pkg::iqgpc_quad_s o, n;
    o = '{16'h0100, 16'h0200, 16'h0300, 16'h0400};
    n = '{16'h1100, 16'h1200, 16'h1300, 16'h1400};
    wr(`IQGPC_ADDR_DLY_GAIN_D, {la, lc, 1'b0, gd});
    steady(o);
    @(posedge clk_in);
    drive_q <= n;
    for (int k = 1; k <= 7; k++) begin
      @(posedge clk_in);
      #1;
      chk16(samples_out.a, (k >= 3 + la) ? model(n).a : model(o).a);
      chk16(samples_out.c, (k >= 3 + lc) ? model(n).c : model(o).c);
      chk16(samples_out.d, (k >= 3 + lc) ? model(n).d : model(o).d);
    end
  endtask : lag_step

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Watchdog so a hang still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk_in);
    failures++;
    complete_run();
  end

  initial begin
    // A real falling edge resets every core flop before the first clock
    arst_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    s = '{16'h03e8, 16'h07d0, 16'hf448, 16'hf060};
    steady(s);
    chkq(samples_out, model(s));
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      chk16(rd_val, re[i]);
    end
    wr(`IQGPC_ADDR_DLY_GAIN_D, 16'hffff);
    rd(`IQGPC_ADDR_DLY_GAIN_D);
    chk16(rd_val, 16'hf7ff);
    wr(`IQGPC_ADDR_DLY_GAIN_D, 16'h0400);
    $display("test registers finished");
    wr(`IQGPC_ADDR_GAIN_A, 16'h0200);
    wr(`IQGPC_ADDR_GAIN_B, 16'h0600);
    steady(s);
    chkq(samples_out, model(s));
    ga = 11'h200;
    gb = 11'h600;
    ph = 12'h400;
    wr(`IQGPC_ADDR_PHASE_DUAL, 16'h0400);
    steady(s);
    chkq(samples_out, model(s));
    $display("test staging finished");
    gd = 11'h7ff;
    ph = 12'h800;
    wr(`IQGPC_ADDR_DLY_GAIN_D, 16'h07ff);
    wr(`IQGPC_ADDR_PHASE_DUAL, 16'h0800);
    steady(s);
    chkq(samples_out, model(s));
    steady('{16'h7fff, 16'h8000, 16'h7fff, 16'h8000});
    chkq(samples_out, model('{16'h7fff, 16'h8000, 16'h7fff, 16'h8000}));
    // Zero A gain leaves only the phase term; half D gain moves the point
    ga = 11'h000;
    gd = 11'h200;
    ph = 12'h400;
    wr(`IQGPC_ADDR_GAIN_A, 16'h0000);
    wr(`IQGPC_ADDR_DLY_GAIN_D, 16'h0200);
    wr(`IQGPC_ADDR_PHASE_DUAL, 16'h0400);
    steady(s);
    chkq(samples_out, model(s));
    $display("test arithmetic finished");
    // Sync disabled: phase write must not load the staged gain
    wr(`IQGPC_ADDR_SYNC_EN, 16'h0000);
    wr(`IQGPC_ADDR_GAIN_A, 16'h0400);
    wr(`IQGPC_ADDR_PHASE_DUAL, 16'h0000);
    steady(s);
    chkq(samples_out, model(s));
    wr(`IQGPC_ADDR_SYNC_EN, 16'h0001);
    wr(`IQGPC_ADDR_PHASE_DUAL, 16'h0000);
    ga = 11'h400;
    ph = 12'h000;
    steady(s);
    chkq(samples_out, model(s));
    $display("test sync finished");
    for (int l = 0; l < 4; l++) begin
      lag_step(2'(l), 2'(3 - l));
    end
    lag_step(2'h1, 2'h1);
    $display("test lags finished");
    wr(`IQGPC_ADDR_PHASE_DUAL, 16'h3000);
    steady(s);
    chk16({15'h0000, dual_mode_out}, 16'h0000);
    wr(`IQGPC_ADDR_CFG1, 16'h0000);
    dual = 1'b1;
    steady(s);
    chk16({15'h0000, dual_mode_out}, 16'h0001);
    chkq(samples_out, model(s));
    wr(`IQGPC_ADDR_PHASE_DUAL, 16'h2000);
    dual = 1'b0;
    steady(s);
    chkq(samples_out, model(s));
    $display("test dual finished");
    complete_run();
  end
endmodule : tb
